//--- rtl/timer_pkg.sv
// Shared constants, control word layout and helpers for the dual timer block.
// Assumes one 20 MHz clock for both ends and a byte-wide I/O port bus.
package timer_pkg;

	// ----------------------------------------------------------------
	// Port map
	// ----------------------------------------------------------------
	localparam logic [7:0] TIMER_BASE    = 8'hd8;
	localparam logic [7:0] TIMER0_CTR0   = 8'hd8;
	localparam logic [7:0] TIMER0_CTRL   = 8'hdb;
	localparam logic [7:0] TIMER1_CTR0   = 8'hdc;
	localparam logic [7:0] TIMER1_CTRL   = 8'hdf;
	localparam logic [1:0] CTRL_SEL      = 2'h3;
	localparam int         CHANNELS      = 6;
	localparam int         PER_CHIP      = 3;

	// ----------------------------------------------------------------
	// Control word fields
	// ----------------------------------------------------------------
	localparam int SEL_MSB  = 7;
	localparam int SEL_LSB  = 6;
	localparam int ACC_MSB  = 5;
	localparam int ACC_LSB  = 4;
	localparam int MODE_MSB = 3;
	localparam int MODE_LSB = 1;
	localparam int BCD_BIT  = 0;

	typedef enum logic [1:0] {
		ACC_LATCH = 2'h0,
		ACC_HIGH  = 2'h1,
		ACC_LOW   = 2'h2,
		ACC_BOTH  = 2'h3
	} access_t;

	localparam logic [2:0] MODE_RESET     = 3'h0;
	localparam logic [7:0] CTRL_RESET     = 8'h00;
	localparam logic [7:0] CMD_SQUARE_C0  = 8'h36;
	localparam logic [7:0] CMD_SQUARE_C1  = 8'h76;
	localparam logic [7:0] CMD_SQUARE_C2  = 8'hb6;
	localparam logic [7:0] CMD_STROBE_C1  = 8'h78;
	localparam logic [7:0] CMD_STROBE_C2  = 8'hb8;

	// ----------------------------------------------------------------
	// Timing: counter input clock made from the 20 MHz clock
	// ----------------------------------------------------------------
	localparam longint CLK_HZ       = 64'd20000000;
	localparam longint SLOW_HZ      = 64'd1228800;
	localparam longint FAST_HZ      = 64'd1843200;
	localparam int     ACC_W        = 24;
	localparam logic [ACC_W-1:0] INC_SLOW = ACC_W'((SLOW_HZ << ACC_W) / CLK_HZ);
	localparam logic [ACC_W-1:0] INC_FAST = ACC_W'((FAST_HZ << ACC_W) / CLK_HZ);

	localparam logic [16:0] MAX_BIN = 17'h10000;
	localparam logic [16:0] MAX_BCD = 17'h02710;

	// Four BCD digits to binary
	function automatic logic [16:0] bcd2bin(input logic [15:0] v);
		bcd2bin = 17'(v[15:12]) * 17'd1000 + 17'(v[11:8]) * 17'd100
			+ 17'(v[7:4]) * 17'd10 + 17'(v[3:0]);
	endfunction

	// Binary below 10000 to four BCD digits
	function automatic logic [15:0] bin2bcd(input logic [15:0] v);
		logic [15:0] r;
		r = v % 16'd10000;
		bin2bcd = {4'(r / 16'd1000), 4'((r / 16'd100) % 16'd10),
			4'((r / 16'd10) % 16'd10), 4'(r % 16'd10)};
	endfunction

endpackage

//--- rtl/timer_io_if.sv
// Byte-wide I/O port bus between the host processor and the timer block.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface timer_io_if;
	logic [7:0] io_addr;
	logic [7:0] io_wdata;
	logic       io_wr;
	logic       io_rd;
	logic [7:0] io_rdata;
	logic       io_rvalid;

	modport device_end (
		input  io_addr,
		input  io_wdata,
		input  io_wr,
		input  io_rd,
		output io_rdata,
		output io_rvalid
	);

	modport host_end (
		output io_addr,
		output io_wdata,
		output io_wr,
		output io_rd,
		input  io_rdata,
		input  io_rvalid
	);
endinterface

//--- rtl/dual_interval_timer_block.sv
// Device end: two interval timer chips of three counters each on the I/O bus.
// Assumes the host keeps to the load and read byte sequences.
`timescale 1ns/1ps

// Contract
// [RULE1] Chips decode d8-db and dc-df
// [RULE2] Low three ports select counters 0,1,2
// [RULE3] Top port takes control words, field selects
// [RULE4] Host writes control, then low, high
// [RULE5] Host sends programmed bytes, BCD when set
// [RULE6] Square reload waits for period end
// [RULE7] Strobe: first byte halts count
// [RULE8] Strobe: second byte restarts count
// [RULE9] Square counters readable and reloadable anytime
// [RULE10] Latch command freezes a count snapshot
// [RULE11] Host latches, then reads data port
// [RULE12] Host finishes every started read
// [RULE13] Two-byte reads low then high
// [RULE14] Input clock 1.2288 MHz, option 1.8432
// [RULE15] Six counters drive outputs, 0-3 serial
// [RULE16] Loaded count is the clock divisor
// [RULE17] Typical: binary, four square, two strobe
// [RULE18] Host uses documented control word values
// [RULE19] Square: high ceil(N/2), low floor(N/2)
// [RULE20] Strobe: one low clock at terminal
// [RULE21] Zero count means 2^16 or 10^4
// [RULE22] Control word chooses byte access
// [RULE23] One decrement per input clock tick
// [RULE24] Separate load and read byte state
module dual_interval_timer_block
	import timer_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        fast_clock_sel,
	timer_io_if.device_end   bus,
	output wire logic [5:0]  rate_out,
	output wire logic [3:0]  serial_tx_bit_clock,
	output wire logic [3:0]  serial_rx_bit_clock,
	output wire logic        interval_tick_irq
);

	// ----------------------------------------------------------------
	// Counter input clock tick
	// ----------------------------------------------------------------
	logic             sel_meta_ff;
	logic             sel_sync_ff;
	logic [ACC_W-1:0] phase_ff;
	logic             tick_ff;
	logic [ACC_W:0]   nxt_phase;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sel_meta_ff <= 1'b0;
			sel_sync_ff <= 1'b0;
		end else begin
			sel_meta_ff <= fast_clock_sel;
			sel_sync_ff <= sel_meta_ff;
		end
	end

	// [RULE14] Rate select
	assign nxt_phase = {1'b0, phase_ff} + {1'b0, (sel_sync_ff ? INC_FAST : INC_SLOW)};

	// [RULE23] Tick on carry
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			phase_ff <= '0;
			tick_ff  <= 1'b0;
		end else begin
			phase_ff <= nxt_phase[ACC_W-1:0];
			tick_ff  <= nxt_phase[ACC_W];
		end
	end

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	wire       in_range = (bus.io_addr[7:3] == TIMER_BASE[7:3]);
	wire       chip_hi  = bus.io_addr[2];
	wire [1:0] port_sel = bus.io_addr[1:0];
	wire       is_ctrl  = (port_sel == CTRL_SEL);
	wire [1:0] ctl_sel  = bus.io_wdata[SEL_MSB:SEL_LSB];
	wire [1:0] ctl_acc  = bus.io_wdata[ACC_MSB:ACC_LSB];

	logic [7:0] rd_byte [CHANNELS];
	logic [5:0] out_bits;

	// ----------------------------------------------------------------
	// Counters
	// ----------------------------------------------------------------
	for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
		localparam logic       CHIP  = (i >= PER_CHIP);
		localparam logic [1:0] LOCAL = 2'(i % PER_CHIP);

		logic [2:0]  mode_ff;
		logic        bcd_ff;
		logic [1:0]  acc_ff;
		logic [16:0] div_ff;
		logic [16:0] cnt_ff;
		logic [16:0] per_ff;
		logic [15:0] latch_ff;
		logic        latched_ff;
		logic        wr_hi_ff;
		logic        rd_hi_ff;
		logic        run_ff;
		logic        out_ff;
		logic [7:0]  lsb_ff;

		// [RULE1] Chip decode
		wire chip_hit = in_range && (chip_hi == CHIP);
		// [RULE3] Control port with counter field
		wire ctl_hit  = bus.io_wr && chip_hit && is_ctrl && (ctl_sel == LOCAL);
		wire latch_wr = ctl_hit && (ctl_acc == ACC_LATCH);
		wire mode_wr  = ctl_hit && (ctl_acc != ACC_LATCH);
		// [RULE2] Data port per counter
		wire data_wr  = bus.io_wr && chip_hit && (port_sel == LOCAL);
		wire data_rd  = bus.io_rd && chip_hit && (port_sel == LOCAL);

		wire square   = (mode_ff[1:0] == 2'h3);
		wire both     = (acc_ff == ACC_BOTH);
		wire first_wr = data_wr && both && !wr_hi_ff;
		wire load_wr  = data_wr && !first_wr;

		// [RULE22] Byte access selects the loaded bytes
		wire [15:0] load_val = (acc_ff == ACC_LOW)  ? {8'h00, bus.io_wdata} :
		                       (acc_ff == ACC_HIGH) ? {bus.io_wdata, 8'h00} :
		                                              {bus.io_wdata, lsb_ff};
		// [RULE21] Zero loads the maximum count
		wire [16:0] new_div  = (load_val == 16'h0000) ? (bcd_ff ? MAX_BCD : MAX_BIN) :
		                       (bcd_ff ? bcd2bin(load_val) : {1'b0, load_val});

		wire [15:0] live_val = bcd_ff ? bin2bcd(cnt_ff[15:0]) : cnt_ff[15:0];
		wire [15:0] show_val = latched_ff ? latch_ff : live_val;
		wire        rd_high  = (acc_ff == ACC_HIGH) || (both && rd_hi_ff);
		wire        last_rd  = !both || rd_hi_ff;
		// [RULE16] Period of div_ff ticks
		wire [16:0] nxt_cnt  = (cnt_ff <= 17'h00001) ? div_ff : cnt_ff - 17'h00001;
		wire        wrap     = (cnt_ff <= 17'h00001);

		// [RULE13] Low byte, then high byte
		assign rd_byte[i]  = rd_high ? show_val[15:8] : show_val[7:0];
		assign out_bits[i] = out_ff;

		// [RULE10] Snapshot kept until fully read
		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				latch_ff   <= '0;
				latched_ff <= 1'b0;
				rd_hi_ff   <= 1'b0;
			end else if (mode_wr) begin
				latched_ff <= 1'b0;
				rd_hi_ff   <= 1'b0;
			end else if (latch_wr && !latched_ff) begin
				latch_ff   <= live_val;
				latched_ff <= 1'b1;
			end else if (data_rd) begin
				// [RULE24] Read byte state
				rd_hi_ff   <= both && !rd_hi_ff;
				if (last_rd) begin
					latched_ff <= 1'b0;
				end
			end
		end

		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				mode_ff  <= MODE_RESET;
				bcd_ff   <= 1'b0;
				acc_ff   <= ACC_BOTH;
				div_ff   <= MAX_BIN;
				cnt_ff   <= '0;
				per_ff   <= MAX_BIN;
				wr_hi_ff <= 1'b0;
				run_ff   <= 1'b0;
				out_ff   <= 1'b1;
				lsb_ff   <= '0;
			end else if (mode_wr) begin
				mode_ff  <= bus.io_wdata[MODE_MSB:MODE_LSB];
				bcd_ff   <= bus.io_wdata[BCD_BIT];
				acc_ff   <= ctl_acc;
				wr_hi_ff <= 1'b0;
				run_ff   <= 1'b0;
				out_ff   <= 1'b1;
			end else if (first_wr) begin
				// [RULE24] Load byte state
				lsb_ff   <= bus.io_wdata;
				wr_hi_ff <= 1'b1;
				// [RULE7] Halt strobe count
				if (!square) begin
					run_ff <= 1'b0;
				end
			end else if (load_wr) begin
				wr_hi_ff <= 1'b0;
				div_ff   <= new_div;
				// [RULE6] Running square keeps its period
				// [RULE9] Reload any time
				// [RULE8] Restart from new value
				if (!square || !run_ff) begin
					cnt_ff <= new_div;
					per_ff <= new_div;
					run_ff <= 1'b1;
					out_ff <= 1'b1;
				end
			end else if (tick_ff && run_ff) begin
				if (square) begin
					// [RULE19] High while above half
					cnt_ff <= nxt_cnt;
					out_ff <= wrap || (nxt_cnt > {1'b0, per_ff[16:1]});
					// [RULE6] New divisor only from period start
					if (wrap) begin
						per_ff <= div_ff;
					end
				end else if (cnt_ff == 17'h00001) begin
					// [RULE20] One low clock at terminal
					cnt_ff <= '0;
					out_ff <= 1'b0;
				end else if (cnt_ff == 17'h00000) begin
					out_ff <= 1'b1;
					run_ff <= 1'b0;
				end else begin
					cnt_ff <= cnt_ff - 17'h00001;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Read data return
	// ----------------------------------------------------------------
	wire [2:0] rd_idx   = 3'(chip_hi ? 2'(PER_CHIP) : 2'h0) + 3'(port_sel);
	wire       rd_hit   = bus.io_rd && in_range && !is_ctrl;
	logic [7:0] rdata_ff;
	logic       rvalid_ff;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_ff  <= '0;
			rvalid_ff <= 1'b0;
		end else begin
			rdata_ff  <= rd_hit ? rd_byte[rd_idx] : 8'h00;
			rvalid_ff <= bus.io_rd;
		end
	end

	assign bus.io_rdata  = rdata_ff;
	assign bus.io_rvalid = rvalid_ff;

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// [RULE15] Counter outputs to serial clocks
	assign rate_out            = out_bits;
	assign serial_tx_bit_clock = out_bits[3:0];
	assign serial_rx_bit_clock = out_bits[3:0];
	assign interval_tick_irq   = out_bits[5];

endmodule

//--- rtl/timer_host_end.sv
// Host end: issues byte port transfers and whole setup or read sequences.
// Assumes the device answers each read one clock after the strobe.
`timescale 1ns/1ps
module timer_host_end
	import timer_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	timer_io_if.host_end     bus,
	input  wire logic        cmd_valid,
	input  wire logic [1:0]  cmd_op,
	input  wire logic [2:0]  cmd_counter,
	input  wire logic [7:0]  cmd_ctrl,
	input  wire logic [15:0] cmd_data,
	output wire logic        cmd_ready,
	output wire logic        done,
	output wire logic [15:0] result
);

	// Op 0 write byte, 1 read byte, 2 setup counter, 3 latch and read 16 bits
	typedef enum {S_IDLE, S_CTRL, S_LO, S_HI, S_WAIT} state_t;

	state_t      state_ff;
	logic [1:0]  op_ff;
	logic [7:0]  ctrl_ff;
	logic [15:0] data_ff;
	logic [7:0]  addr_ff;
	logic [7:0]  wdata_ff;
	logic        wr_ff;
	logic        rd_ff;
	logic        hi_ff;
	logic        done_ff;
	logic [15:0] result_ff;
	logic [2:0]  ctr_ff;

	wire        chip  = (cmd_counter >= 3'(PER_CHIP));
	wire [1:0]  local_sel = 2'(chip ? cmd_counter - 3'(PER_CHIP) : cmd_counter);
	wire        chip_q    = (ctr_ff >= 3'(PER_CHIP));
	wire [1:0]  local_q   = 2'(chip_q ? ctr_ff - 3'(PER_CHIP) : ctr_ff);
	wire [7:0]  data_port = (chip_q ? TIMER1_CTR0 : TIMER0_CTR0) + {6'h00, local_q};
	wire [7:0]  ctrl_port = chip ? TIMER1_CTRL : TIMER0_CTRL;
	wire [7:0]  latch_cmd = {local_sel, ACC_LATCH, 4'h0};

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff  <= S_IDLE;
			op_ff     <= '0;
			ctrl_ff   <= CTRL_RESET;
			data_ff   <= '0;
			addr_ff   <= '0;
			wdata_ff  <= '0;
			wr_ff     <= 1'b0;
			rd_ff     <= 1'b0;
			hi_ff     <= 1'b0;
			done_ff   <= 1'b0;
			result_ff <= '0;
			ctr_ff    <= '0;
		end else begin
			wr_ff   <= 1'b0;
			rd_ff   <= 1'b0;
			done_ff <= 1'b0;
			case (state_ff)
				S_IDLE: if (cmd_valid) begin
					op_ff    <= cmd_op;
					ctrl_ff  <= cmd_ctrl;
					data_ff  <= cmd_data;
					ctr_ff   <= cmd_counter;
					hi_ff    <= 1'b0;
					wdata_ff <= cmd_data[7:0];
					case (cmd_op)
						2'h0: begin
							addr_ff  <= cmd_data[15:8];
							wr_ff    <= 1'b1;
							done_ff  <= 1'b1;
						end
						2'h1: begin
							addr_ff  <= cmd_data[15:8];
							rd_ff    <= 1'b1;
							state_ff <= S_WAIT;
						end
						2'h2: begin
							// [RULE4] Control word first
							addr_ff  <= ctrl_port;
							wdata_ff <= cmd_ctrl;
							wr_ff    <= 1'b1;
							state_ff <= S_LO;
						end
						default: begin
							// [RULE11] Latch before read
							addr_ff  <= ctrl_port;
							wdata_ff <= latch_cmd;
							wr_ff    <= 1'b1;
							state_ff <= S_LO;
						end
					endcase
				end
				S_LO: begin
					addr_ff <= data_port;
					if (op_ff == 2'h2) begin
						wdata_ff <= data_ff[7:0];
						wr_ff    <= 1'b1;
						state_ff <= S_HI;
					end else begin
						// [RULE13] Low byte first
						rd_ff    <= 1'b1;
						state_ff <= S_WAIT;
					end
				end
				S_HI: begin
					// [RULE5] Always low then high byte of the data, whatever byte access the control word programs
					wdata_ff <= data_ff[15:8];
					wr_ff    <= 1'b1;
					done_ff  <= 1'b1;
					state_ff <= S_IDLE;
				end
				S_WAIT: if (bus.io_rvalid) begin
					if (op_ff == 2'h3 && !hi_ff) begin
						// [RULE12] Finish both bytes
						result_ff[7:0] <= bus.io_rdata;
						hi_ff          <= 1'b1;
						rd_ff          <= 1'b1;
					end else begin
						if (op_ff == 2'h3) begin
							result_ff[15:8] <= bus.io_rdata;
						end else begin
							result_ff <= {8'h00, bus.io_rdata};
						end
						done_ff  <= 1'b1;
						state_ff <= S_IDLE;
					end
				end
				default: state_ff <= S_IDLE;
			endcase
		end
	end

	assign bus.io_addr  = addr_ff;
	assign bus.io_wdata = wdata_ff;
	assign bus.io_wr    = wr_ff;
	assign bus.io_rd    = rd_ff;
	assign cmd_ready    = (state_ff == S_IDLE) && !done_ff && !wr_ff;
	assign done         = done_ff;
	assign result       = result_ff;

endmodule

//--- bench/dual_interval_timer_block_chk.sv
// Checker: I/O bus answers and counter output relations of the timer block.
// Assumes it is instantiated beside the interface in the bench top.
`timescale 1ns/1ps
module dual_interval_timer_block_chk
	import timer_pkg::*;
(
	input wire logic       clk,
	input wire logic       reset_n,
	input wire logic [7:0] io_addr,
	input wire logic       io_rd,
	input wire logic [7:0] io_rdata,
	input wire logic       io_rvalid,
	input wire logic [5:0] rate_out,
	input wire logic [3:0] serial_tx_bit_clock,
	input wire logic [3:0] serial_rx_bit_clock,
	input wire logic       interval_tick_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_read_answered: assert property (io_rd |=> io_rvalid)
		else $error("read strobe not answered next cycle");
	a_answer_cause: assert property (io_rvalid |-> $past(io_rd))
		else $error("read answer without a read strobe");
	a_ctrl_read_zero: assert property ((io_rd && (io_addr == TIMER0_CTRL ||
		io_addr == TIMER1_CTRL)) |=> io_rdata == 8'h00)
		else $error("control port read returned data");
	a_unmapped_zero: assert property ((io_rd && io_addr < TIMER_BASE) |=> io_rdata == 8'h00)
		else $error("unmapped read returned data");
	a_tx_clock_map: assert property (serial_tx_bit_clock == rate_out[3:0])
		else $error("transmit clocks differ from counter outputs");
	a_rx_clock_map: assert property (serial_rx_bit_clock == rate_out[3:0])
		else $error("receive clocks differ from counter outputs");
	a_tick_irq_map: assert property (interval_tick_irq == rate_out[5])
		else $error("interval interrupt differs from last counter");
	a_strobe_one_tick: assert property ($fell(rate_out[5]) |->
		!rate_out[5] [*8] ##[2:10] rate_out[5])
		else $error("strobe low time is not one tick");

	c_ctrl_read: cover property (io_rd && io_addr == TIMER0_CTRL);
	c_strobe: cover property ($fell(rate_out[5]));
	c_square: cover property ($rose(rate_out[0]));
endmodule

//--- bench/dual_interval_timer_block_bench.sv
// Bench: host end and device end joined by the I/O port interface.
// Assumes the host command port contract; expectations come from the rules.
`timescale 1ns/1ps
module dual_interval_timer_block_bench
	import timer_pkg::*;
;
	typedef struct {
		logic [2:0]  ctr;
		logic [7:0]  ctrl;
		logic [15:0] cnt;
		logic        fast;
		int          hi;
		int          lo;
	} row_t;

	logic        clk;
	logic        reset_n;
	logic        fast_clock_sel;
	logic        cmd_valid;
	logic [1:0]  cmd_op;
	logic [2:0]  cmd_counter;
	logic [7:0]  cmd_ctrl;
	logic [15:0] cmd_data;
	logic        cmd_ready;
	logic        done;
	logic [15:0] result;
	logic [5:0]  rate_out;
	logic [3:0]  tx_clk;
	logic [3:0]  rx_clk;
	logic        tick_irq;
	int          err_count = 0;
	int          checks = 0;
	int          cycles = 0;
	int          n;
	int          hi;
	int          lo;
	real         tk;
	logic [15:0] v1;
	row_t        rows [5];

	timer_io_if io ();

	dual_interval_timer_block i_dual_interval_timer_block (
		.clk                 (clk),
		.reset_n             (reset_n),
		.fast_clock_sel      (fast_clock_sel),
		.bus                 (io),
		.rate_out            (rate_out),
		.serial_tx_bit_clock (tx_clk),
		.serial_rx_bit_clock (rx_clk),
		.interval_tick_irq   (tick_irq)
	);

	timer_host_end i_timer_host_end (
		.clk         (clk),
		.reset_n     (reset_n),
		.bus         (io),
		.cmd_valid   (cmd_valid),
		.cmd_op      (cmd_op),
		.cmd_counter (cmd_counter),
		.cmd_ctrl    (cmd_ctrl),
		.cmd_data    (cmd_data),
		.cmd_ready   (cmd_ready),
		.done        (done),
		.result      (result)
	);

	dual_interval_timer_block_chk i_dual_interval_timer_block_chk (
		.clk                 (clk),
		.reset_n             (reset_n),
		.io_addr             (io.io_addr),
		.io_rd               (io.io_rd),
		.io_rdata            (io.io_rdata),
		.io_rvalid           (io.io_rvalid),
		.rate_out            (rate_out),
		.serial_tx_bit_clock (tx_clk),
		.serial_rx_bit_clock (rx_clk),
		.interval_tick_irq   (tick_irq)
	);

	// ----------------------------------------------------------------
	// Clock, timeout and tasks
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_near(input string nm, input real e, input real tol, input int g);
		checks++;
		if (g - e > tol || e - g > tol) begin
			err_count++;
			$display("ERROR %s expected %0.1f seen %0d", nm, e, g);
		end
	endtask

	task automatic run_cmd(input logic [1:0] op, input logic [2:0] c, input logic [7:0] w,
		input logic [15:0] d);
		int k;
		k = 0;
		while (cmd_ready !== 1'b1 && k < 50) begin
			@(posedge clk);
			#1;
			k++;
		end
		cmd_op = op;
		cmd_counter = c;
		cmd_ctrl = w;
		cmd_data = d;
		cmd_valid = 1'b1;
		@(posedge clk);
		#1;
		cmd_valid = 1'b0;
		k = 0;
		while (done !== 1'b1 && k < 50) begin
			@(posedge clk);
			#1;
			k++;
		end
		chk_val("done", 16'h0001, 16'(k < 50));
	endtask

	// Cycles until counter output b shows level lv, at most 4000
	task automatic wait_lvl(input int b, input logic lv, output int k);
		k = 0;
		while (rate_out[b] !== lv && k < 4000) begin
			@(posedge clk);
			#1;
			k++;
		end
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		reset_n = 1'b0;
		fast_clock_sel = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = 2'h0;
		cmd_counter = 3'h0;
		cmd_ctrl = 8'h00;
		cmd_data = 16'h0000;
		rows = '{'{3'h0, 8'h36, 16'h0005, 1'b0, 3, 2}, '{3'h1, 8'h76, 16'h0004, 1'b0, 2, 2},
			'{3'h2, 8'hb6, 16'h0007, 1'b1, 4, 3}, '{3'h3, 8'h36, 16'h0006, 1'b1, 3, 3},
			'{3'h0, 8'h37, 16'h0011, 1'b0, 6, 5}};
		repeat (8) @(posedge clk);
		#1;
		chk_val("rate_out_reset", 16'h003f, 16'(rate_out));
		chk_val("ready_reset", 16'h0001, 16'(cmd_ready));
		reset_n = 1'b1;
		foreach (rows[i]) begin
			fast_clock_sel = rows[i].fast;
			tk = real'(CLK_HZ) / real'(rows[i].fast ? FAST_HZ : SLOW_HZ);
			repeat (4) @(posedge clk);
			#1;
			run_cmd(2'h2, rows[i].ctr, rows[i].ctrl, rows[i].cnt);
			wait_lvl(rows[i].ctr, 1'b0, n);
			wait_lvl(rows[i].ctr, 1'b1, n);
			wait_lvl(rows[i].ctr, 1'b0, hi);
			wait_lvl(rows[i].ctr, 1'b1, lo);
			chk_near("square_high", rows[i].hi * tk, 1.5, hi);
			chk_near("square_low", rows[i].lo * tk, 1.5, lo);
		end
		// Counter 1 still runs a count of 4; reload 8 in its high phase
		wait_lvl(1, 1'b0, n);
		wait_lvl(1, 1'b1, n);
		run_cmd(2'h0, 3'h0, 8'h00, 16'hd908);
		run_cmd(2'h0, 3'h0, 8'h00, 16'hd900);
		wait_lvl(1, 1'b0, n);
		wait_lvl(1, 1'b1, lo);
		wait_lvl(1, 1'b0, hi);
		chk_near("reload_low", 2.0 * tk, 1.5, lo);
		chk_near("reload_high", 4.0 * tk, 1.5, hi);
		// Low byte only load and single byte read on counter 2
		run_cmd(2'h0, 3'h0, 8'h00, 16'hdba6);
		run_cmd(2'h0, 3'h0, 8'h00, 16'hda06);
		wait_lvl(2, 1'b0, n);
		wait_lvl(2, 1'b1, n);
		wait_lvl(2, 1'b0, hi);
		wait_lvl(2, 1'b1, lo);
		chk_near("low_only_high", 3.0 * tk, 1.5, hi);
		chk_near("low_only_low", 3.0 * tk, 1.5, lo);
		run_cmd(2'h0, 3'h0, 8'h00, 16'hdb80);
		run_cmd(2'h1, 3'h0, 8'h00, 16'hda00);
		chk_val("low_only_read", 16'h0001, 16'(result[7:0] inside {[1:6]}));
		run_cmd(2'h1, 3'h0, 8'h00, 16'hdb00);
		chk_val("ctrl_read", 16'h0000, {8'h00, result[7:0]});
		run_cmd(2'h1, 3'h0, 8'h00, 16'h1000);
		chk_val("unmapped_read", 16'h0000, {8'h00, result[7:0]});
		// Strobe timer on the last counter
		run_cmd(2'h2, 3'h5, 8'hb8, 16'h0014);
		wait_lvl(5, 1'b0, n);
		chk_near("strobe_delay", 20.0 * tk, tk + 2.0, n);
		wait_lvl(5, 1'b1, n);
		chk_near("strobe_width", tk, 1.5, n);
		wait_lvl(5, 1'b0, n);
		chk_val("strobe_once", 16'd4000, 16'(n));
		// Latched snapshot, halt and restart of a strobe counter
		run_cmd(2'h2, 3'h4, 8'h78, 16'h1234);
		run_cmd(2'h0, 3'h0, 8'h00, 16'hdf40);
		repeat (200) @(posedge clk);
		run_cmd(2'h1, 3'h0, 8'h00, 16'hdd00);
		v1[7:0] = result[7:0];
		run_cmd(2'h1, 3'h0, 8'h00, 16'hdd00);
		v1[15:8] = result[7:0];
		chk_val("latched", 16'h0001, 16'(v1 <= 16'h1234 && v1 >= 16'h1231));
		run_cmd(2'h0, 3'h0, 8'h00, 16'hdd00);
		run_cmd(2'h3, 3'h4, 8'h00, 16'h0000);
		v1 = result;
		repeat (100) @(posedge clk);
		run_cmd(2'h3, 3'h4, 8'h00, 16'h0000);
		chk_val("halted", v1, result);
		run_cmd(2'h0, 3'h0, 8'h00, 16'hdd02);
		run_cmd(2'h3, 3'h4, 8'h00, 16'h0000);
		chk_val("restart", 16'h0001, 16'(result <= 16'h0200 && result >= 16'h01fd));
		end_of_test();
	end
endmodule
